// ==== hdl/amsw_params.svh ====
// Constants of the per-axis main status word block
// Function
// (RULE1) Bit 0 set by start, cleared by stop
// (RULE2) Bit 1 is the inverted busy pin
// (RULE3) Bit 2 stop interrupt, zero when disabled
// (RULE4) Mode 0: stop flag clears after read
// (RULE5) Mode 1: only clear command clears it; the code also clears it when stopIrqEnable is low
// (RULE6) Bit 3 set by stop, cleared by start
// (RULE7) Bit 4 pending until error causes clear
// (RULE8) Bit 5 pending until event causes clear
// (RULE9) Bits 7:6 carry the sequence number
// (RULE10) Bits 9:8 carry general comparator results
// (RULE11) Bit 10: selected counter above compare three
// (RULE12) Counter selectable; maximum compare holds bit low
// (RULE13) Bit 11: selected counter below compare four
// (RULE14) Bit 12 always reads zero
// (RULE15) Word snapshot taken at axis select end
`ifndef AMSW_PARAMS_SVH
`define AMSW_PARAMS_SVH

// Field widths
`define AMSW_WORD_WIDTH       16
`define AMSW_COUNT_WIDTH      32
`define AMSW_CAUSE_WIDTH      32
`define AMSW_SEQ_WIDTH        2
`define AMSW_SEL_WIDTH        2
`define AMSW_CAUSE_COUNT      2

// Bit positions of the status word
`define AMSW_BIT_START        0
`define AMSW_BIT_MOVING       1
`define AMSW_BIT_STOP_IRQ     2
`define AMSW_BIT_STOPPED      3
`define AMSW_BIT_ERROR_IRQ    4
`define AMSW_BIT_EVENT_IRQ    5
`define AMSW_BIT_SEQ_LO       6
`define AMSW_BIT_SEQ_HI       7
`define AMSW_BIT_CMP_A        8
`define AMSW_BIT_CMP_B        9
`define AMSW_BIT_POS_LIMIT    10
`define AMSW_BIT_NEG_LIMIT    11
`define AMSW_BIT_UNDEF_LO     12
`define AMSW_BIT_OFF_TARGET   13
`define AMSW_BIT_PREREG       14
`define AMSW_BIT_UNDEF_HI     15

// Cause slots in the pending flag array
`define AMSW_CAUSE_ERROR      0
`define AMSW_CAUSE_EVENT      1

// Reset values and fixed values
`define AMSW_WORD_RESET       16'h0000
`define AMSW_COUNT_RESET      32'h0000_0000
`define AMSW_CAUSE_RESET      32'h0000_0000
`define AMSW_COUNT_MAX        32'h7FFF_FFFF

// Longest time, in reference clocks, for the stop flag to clear
`define AMSW_CLEAR_MAX_CYCLES 3

`endif

// ==== hdl/amsw_pkg.sv ====
// Types shared by the main status word block
`include "amsw_params.svh"

package amsw_pkg;

	// Status word and counter types
	typedef logic [`AMSW_WORD_WIDTH-1:0]         amsw_word_t;
	typedef logic signed [`AMSW_COUNT_WIDTH-1:0] amsw_count_t;
	typedef logic [`AMSW_CAUSE_WIDTH-1:0]        amsw_cause_t;
	typedef logic [`AMSW_SEQ_WIDTH-1:0]          amsw_seq_t;

	// Counter watched by the software limits
	typedef enum logic [`AMSW_SEL_WIDTH-1:0]
	{
		AMSW_SEL_COMMAND    = 2'h0,
		AMSW_SEL_MECHANICAL = 2'h1,
		AMSW_SEL_DEVIATION  = 2'h2,
		AMSW_SEL_GENERAL    = 2'h3
	} amsw_limit_sel_t;

endpackage

// ==== hdl/amsw_cause_flag.sv ====
// Pending flag that follows a cause register
`timescale 1ns/10ps
`include "amsw_params.svh"

module amsw_cause_flag
(
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// Cause register bits
	input  wire amsw_pkg::amsw_cause_t cause,
	// Pending flag
	output logic                     pending
);

	amsw_pkg::amsw_cause_t causePrev_reg;
	amsw_pkg::amsw_cause_t causePrev_next;
	logic                  pending_reg;
	logic                  pending_next;
	logic                  newCause;
	logic                  allCleared;

	// A bit going high sets the flag; all bits back to zero clear it
	always_comb
	begin
		newCause       = |(cause & ~causePrev_reg);
		allCleared     = (|causePrev_reg) && !(|cause);
		causePrev_next = cause;
		pending_next   = pending_reg;
		if (newCause)
			pending_next = 1'b1;
		else if (allCleared)
			pending_next = 1'b0;
	end

	// Register the cause history and the flag
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			causePrev_reg <= `AMSW_CAUSE_RESET;
			pending_reg   <= 1'b0;
		end
		else
		begin
			causePrev_reg <= causePrev_next;
			pending_reg   <= pending_next;
		end
	end

	assign pending = pending_reg;

	// Flag drops one cycle after the last cause bit falls
	cause_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE7 RULE8
		(|causePrev_reg) && !(|cause) |=> !pending_reg)
		else $error("pending flag stayed set after causes cleared");

	// Flag rises one cycle after any cause bit rises
	cause_set_a: assert property (@(posedge clock) disable iff (rst) // RULE7 RULE8
		(|(cause & ~causePrev_reg)) |=> pending_reg)
		else $error("pending flag missed a new cause");

endmodule

// ==== hdl/amsw_soft_limit.sv ====
// Positive and negative software-limit comparators
`timescale 1ns/10ps
`include "amsw_params.svh"

module amsw_soft_limit
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	// Counter choice and counters
	input  wire amsw_pkg::amsw_limit_sel_t select,
	input  wire amsw_pkg::amsw_count_t     counterCommand,
	input  wire amsw_pkg::amsw_count_t     counterMechanical,
	input  wire amsw_pkg::amsw_count_t     counterDeviation,
	input  wire amsw_pkg::amsw_count_t     counterGeneral,
	// Compare values
	input  wire amsw_pkg::amsw_count_t     compareValueThree,
	input  wire amsw_pkg::amsw_count_t     compareValueFour,
	// Comparison results
	output logic                           positiveOver,
	output logic                           negativeUnder
);

	amsw_pkg::amsw_count_t watched;
	logic                  positive_reg;
	logic                  positive_next;
	logic                  negative_reg;
	logic                  negative_next;

	// Pick the counter both limits watch
	always_comb
	begin
		unique case (select) // RULE12
			amsw_pkg::AMSW_SEL_COMMAND:    watched = counterCommand;
			amsw_pkg::AMSW_SEL_MECHANICAL: watched = counterMechanical;
			amsw_pkg::AMSW_SEL_DEVIATION:  watched = counterDeviation;
			amsw_pkg::AMSW_SEL_GENERAL:    watched = counterGeneral;
		endcase
		positive_next = watched > compareValueThree; // RULE11
		negative_next = watched < compareValueFour;  // RULE13
	end

	// Register the comparisons
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			positive_reg <= 1'b0;
			negative_reg <= 1'b0;
		end
		else
		begin
			positive_reg <= positive_next;
			negative_reg <= negative_next;
		end
	end

	assign positiveOver  = positive_reg;
	assign negativeUnder = negative_reg;

	// Maximum compare value holds the positive result low
	limit_hold_a: assert property (@(posedge clock) disable iff (rst) // RULE12
		compareValueThree == `AMSW_COUNT_MAX |=> !positive_reg)
		else $error("positive limit set with maximum compare value");

	// Negative result equals the strict less-than of the watched counter
	neg_limit_a: assert property (@(posedge clock) disable iff (rst) // RULE13
		1'b1 |=> negative_reg == ($past(watched) < $past(compareValueFour)))
		else $error("negative limit result wrong");

endmodule

// ==== hdl/amsw_status_word.sv ====
// Per-axis main status word with host snapshot
`timescale 1ns/10ps
`include "amsw_params.svh"

module amsw_status_word
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	// Axis sequencer events, one-cycle pulses
	input  wire logic                      startCmdWritten,
	input  wire logic                      operationStopped,
	input  wire logic                      stopIrqEvent,
	input  wire logic                      stopIrqClearCmd,
	// Configuration settings
	input  wire logic                      stopIrqEnable,
	input  wire logic                      statusClearMode,
	input  wire amsw_pkg::amsw_seq_t       sequenceNumberSetting,
	input  wire amsw_pkg::amsw_limit_sel_t softLimitCounterSelect,
	// Axis state levels
	input  wire logic                      busyPinN,
	input  wire logic                      comparatorAMet,
	input  wire logic                      comparatorBMet,
	input  wire logic                      offTargetStop,
	input  wire logic                      preregisterFull,
	// Cause registers
	input  wire amsw_pkg::amsw_cause_t     errorCauseReg,
	input  wire amsw_pkg::amsw_cause_t     eventCauseReg,
	// Counters and software-limit compare values
	input  wire amsw_pkg::amsw_count_t     counterCommand,
	input  wire amsw_pkg::amsw_count_t     counterMechanical,
	input  wire amsw_pkg::amsw_count_t     counterDeviation,
	input  wire amsw_pkg::amsw_count_t     counterGeneral,
	input  wire amsw_pkg::amsw_count_t     compareValueThree,
	input  wire amsw_pkg::amsw_count_t     compareValueFour,
	// Host port strobes
	input  wire logic                      axisSelectDone,
	input  wire logic                      statusReadDone,
	// Status word presented to the host port
	output amsw_pkg::amsw_word_t           mainStatusWord
);

	// Bound for the stop flag clear, in reference clocks
	localparam int CLEAR_MAX = `AMSW_CLEAR_MAX_CYCLES;

	// Operation flags
	logic                  startWritten_reg;
	logic                  startWritten_next;
	logic                  stopped_reg;
	logic                  stopped_next;
	logic                  stopIrq_reg;
	logic                  stopIrq_next;

	// Snapshot of the word
	amsw_pkg::amsw_word_t  snapshot_reg;
	amsw_pkg::amsw_word_t  snapshot_next;
	amsw_pkg::amsw_word_t  liveWord;

	// Derived status
	amsw_pkg::amsw_cause_t causeSet [`AMSW_CAUSE_COUNT];
	logic [`AMSW_CAUSE_COUNT-1:0] causePending;
	logic                  positiveOver;
	logic                  negativeUnder;
	logic                  readClear;
	logic                  cmdClear;

	// Cause registers gathered for the pending flags
	assign causeSet[`AMSW_CAUSE_ERROR] = errorCauseReg;
	assign causeSet[`AMSW_CAUSE_EVENT] = eventCauseReg;

	// One pending flag per cause register
	genvar g;
	generate
		for (g = 0; g < `AMSW_CAUSE_COUNT; g++)
		begin : causeFlags
			amsw_cause_flag causeFlag
			(
				.clock   (clock),
				.rst     (rst),
				.cause   (causeSet[g]),
				.pending (causePending[g])
			);
		end
	endgenerate

	// Software-limit comparators on the selected counter
	amsw_soft_limit softLimit
	(
		.clock             (clock),
		.rst               (rst),
		.select            (softLimitCounterSelect),
		.counterCommand    (counterCommand),
		.counterMechanical (counterMechanical),
		.counterDeviation  (counterDeviation),
		.counterGeneral    (counterGeneral),
		.compareValueThree (compareValueThree),
		.compareValueFour  (compareValueFour),
		.positiveOver      (positiveOver),
		.negativeUnder     (negativeUnder)
	);

	// Start, stopped and stop-interrupt flags
	always_comb
	begin
		startWritten_next = startWritten_reg;
		stopped_next      = stopped_reg;
		stopIrq_next      = stopIrq_reg;
		// Clear on read only what the host actually saw in its snapshot
		readClear = statusReadDone && !statusClearMode && snapshot_reg[`AMSW_BIT_STOP_IRQ]; // RULE4
		cmdClear  = stopIrqClearCmd && statusClearMode; // RULE5
		// Start history: a start in the stop cycle still counts
		if (operationStopped)
			startWritten_next = 1'b0;
		if (startCmdWritten)
			startWritten_next = 1'b1; // RULE1
		// Stopped flag: the stop event wins over a simultaneous start
		if (startCmdWritten)
			stopped_next = 1'b0;
		if (operationStopped)
			stopped_next = 1'b1; // RULE6
		// Stop interrupt: set wins over either clear
		if (readClear || cmdClear)
			stopIrq_next = 1'b0;
		if (stopIrqEvent)
			stopIrq_next = 1'b1;
		if (!stopIrqEnable)
			stopIrq_next = 1'b0; // RULE3
	end

	// Register the operation flags
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			startWritten_reg <= 1'b0;
			stopped_reg      <= 1'b0;
			stopIrq_reg      <= 1'b0;
		end
		else
		begin
			startWritten_reg <= startWritten_next;
			stopped_reg      <= stopped_next;
			stopIrq_reg      <= stopIrq_next;
		end
	end

	// Assemble the live word from flags and axis state
	always_comb
	begin
		liveWord                         = `AMSW_WORD_RESET;
		liveWord[`AMSW_BIT_START]        = startWritten_reg;                 // RULE1
		liveWord[`AMSW_BIT_MOVING]       = !busyPinN;                        // RULE2
		liveWord[`AMSW_BIT_STOP_IRQ]     = stopIrq_reg && stopIrqEnable;     // RULE3
		liveWord[`AMSW_BIT_STOPPED]      = stopped_reg;                      // RULE6
		liveWord[`AMSW_BIT_ERROR_IRQ]    = causePending[`AMSW_CAUSE_ERROR];  // RULE7
		liveWord[`AMSW_BIT_EVENT_IRQ]    = causePending[`AMSW_CAUSE_EVENT];  // RULE8
		liveWord[`AMSW_BIT_SEQ_HI:`AMSW_BIT_SEQ_LO] = sequenceNumberSetting; // RULE9
		liveWord[`AMSW_BIT_CMP_A]        = comparatorAMet;                   // RULE10
		liveWord[`AMSW_BIT_CMP_B]        = comparatorBMet;                   // RULE10
		liveWord[`AMSW_BIT_POS_LIMIT]    = positiveOver;                     // RULE11
		liveWord[`AMSW_BIT_NEG_LIMIT]    = negativeUnder;                    // RULE13
		liveWord[`AMSW_BIT_UNDEF_LO]     = 1'b0;                             // RULE14
		liveWord[`AMSW_BIT_OFF_TARGET]   = offTargetStop;
		liveWord[`AMSW_BIT_PREREG]       = preregisterFull;
		liveWord[`AMSW_BIT_UNDEF_HI]     = 1'b0;
	end

	// Hold the word steady while the host shifts it out
	always_comb
	begin
		snapshot_next = snapshot_reg;
		if (axisSelectDone)
			snapshot_next = liveWord; // RULE15
	end

	// Register the snapshot
	always_ff @(posedge clock)
	begin
		if (rst)
			snapshot_reg <= `AMSW_WORD_RESET;
		else
			snapshot_reg <= snapshot_next;
	end

	assign mainStatusWord = snapshot_reg;

	// Start sets the start history flag
	start_flag_a: assert property (@(posedge clock) disable iff (rst) // RULE1
		startCmdWritten |=> startWritten_reg)
		else $error("start history bit not set after start");

	// A lone stop clears the start history flag
	start_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE1
		operationStopped && !startCmdWritten |=> !startWritten_reg)
		else $error("start history bit kept after stop");

	// Moving bit is the inverse of the busy pin at snapshot time
	moving_mirror_a: assert property (@(posedge clock) disable iff (rst) // RULE2
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_MOVING] == !$past(busyPinN))
		else $error("moving bit does not mirror busy pin");

	// Disabled stop interrupt reads zero
	stop_irq_gate_a: assert property (@(posedge clock) disable iff (rst) // RULE3
		!stopIrqEnable && axisSelectDone |=> !mainStatusWord[`AMSW_BIT_STOP_IRQ])
		else $error("stop interrupt bit set while disabled");

	// Enabled stop event sets the flag, even against a clear
	stop_irq_set_a: assert property (@(posedge clock) disable iff (rst) // RULE3
		stopIrqEvent && stopIrqEnable
		|=> stopIrq_reg)
		else $error("stop interrupt not reported");

	// Mode 0: read of a set flag clears it in time
	read_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE4
		statusReadDone && !statusClearMode && snapshot_reg[`AMSW_BIT_STOP_IRQ]
		&& !stopIrqEvent |-> ##[1:CLEAR_MAX] !stopIrq_reg)
		else $error("stop flag not cleared after read");

	// Mode 1: clear command clears it in time
	cmd_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE5
		stopIrqClearCmd && statusClearMode && !stopIrqEvent
		|-> ##[1:CLEAR_MAX] !stopIrq_reg)
		else $error("stop flag not cleared by clear command");

	// Mode 1: a read alone leaves the flag set
	read_keep_a: assert property (@(posedge clock) disable iff (rst) // RULE5
		statusClearMode && stopIrq_reg && stopIrqEnable && !stopIrqClearCmd
		|=> stopIrq_reg)
		else $error("stop flag lost without clear command");

	// Stopped flag follows stop and start
	stopped_flag_a: assert property (@(posedge clock) disable iff (rst) // RULE6
		(operationStopped |=> stopped_reg)
		and (startCmdWritten && !operationStopped |=> !stopped_reg))
		else $error("stopped flag wrong after stop or start");

	// Sequence number is sampled into the snapshot
	seq_field_a: assert property (@(posedge clock) disable iff (rst) // RULE9
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_SEQ_HI:`AMSW_BIT_SEQ_LO]
		== $past(sequenceNumberSetting))
		else $error("sequence field differs from setting");

	// General comparator results copied into the snapshot
	cmp_copy_a: assert property (@(posedge clock) disable iff (rst) // RULE10
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_CMP_A] == $past(comparatorAMet)
		&& mainStatusWord[`AMSW_BIT_CMP_B] == $past(comparatorBMet))
		else $error("comparator bits differ from inputs");

	// Positive limit reported from the comparator
	pos_limit_a: assert property (@(posedge clock) disable iff (rst) // RULE11
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_POS_LIMIT] == $past(positiveOver))
		else $error("positive limit bit wrong");

	// Undefined bits always read zero
	undef_zero_a: assert property (@(posedge clock) disable iff (rst) // RULE14
		!mainStatusWord[`AMSW_BIT_UNDEF_LO] && !mainStatusWord[`AMSW_BIT_UNDEF_HI])
		else $error("undefined status bit reads one");

	// Snapshot holds between axis-select strobes
	snapshot_hold_a: assert property (@(posedge clock) disable iff (rst) // RULE15
		!axisSelectDone |=> $stable(mainStatusWord))
		else $error("status word changed during read");

	// Snapshot takes the whole live word at the select strobe
	snapshot_take_a: assert property (@(posedge clock) disable iff (rst) // RULE15
		axisSelectDone |=> mainStatusWord == $past(liveWord))
		else $error("snapshot differs from live word");

	// Error and event pending flags land in bits 4 and 5
	cause_word_a: assert property (@(posedge clock) disable iff (rst) // RULE7 RULE8
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_EVENT_IRQ:`AMSW_BIT_ERROR_IRQ] == $past(causePending))
		else $error("pending bits differ from cause flags");

	// Negative limit reported from the comparator
	neg_word_a: assert property (@(posedge clock) disable iff (rst) // RULE13
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_NEG_LIMIT] == $past(negativeUnder))
		else $error("negative limit bit wrong");

	// Start history flag reaches the snapshot
	start_word_a: assert property (@(posedge clock) disable iff (rst) // RULE1
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_START] == $past(startWritten_reg))
		else $error("start history bit differs from flag");

	// Stopped flag reaches the snapshot
	stopped_word_a: assert property (@(posedge clock) disable iff (rst) // RULE6
		axisSelectDone |=> mainStatusWord[`AMSW_BIT_STOPPED] == $past(stopped_reg))
		else $error("stopped bit differs from flag");

	// Set and enabled stop flag reaches the snapshot
	stop_word_a: assert property (@(posedge clock) disable iff (rst) // RULE3
		axisSelectDone && stopIrq_reg && stopIrqEnable
		|=> mainStatusWord[`AMSW_BIT_STOP_IRQ])
		else $error("stop interrupt bit missing from snapshot");

	// Disabled stop interrupt also empties the internal flag
	enable_force_a: assert property (@(posedge clock) disable iff (rst) // RULE3
		!stopIrqEnable
		|=> !stopIrq_reg)
		else $error("stop flag kept while disabled");

	// Mode 0: the flag stays set until the host reads it
	clear_keep_a: assert property (@(posedge clock) disable iff (rst) // RULE4
		!statusClearMode && stopIrq_reg && stopIrqEnable && !statusReadDone
		|=> stopIrq_reg)
		else $error("stop flag lost without a read");

endmodule

// ==== testbench/amsw_host_model.sv ====
// Host CPU model that selects the axis and shifts out the main status word
`timescale 1ns/10ps

module amsw_host_model
(
	// Clock
	input  wire logic                 clock,
	// Host port strobes
	output logic                      axisSelectDone,
	output logic                      statusReadDone,
	// Status word from the block
	input  wire amsw_pkg::amsw_word_t mainStatusWord
);
	// Strobes axisSelectDone and statusReadDone low between reads
	initial
	begin
		axisSelectDone = 1'b0;
		statusReadDone = 1'b0;
	end

	// Select byte ends, word is taken, then the read finishes after a prompt or slow gap
	task automatic read_word(output amsw_pkg::amsw_word_t word, input int gap);
		@(negedge clock);
		axisSelectDone = 1'b1;
		@(negedge clock);
		axisSelectDone = 1'b0;
		word = mainStatusWord;
		repeat (gap) @(negedge clock);
		statusReadDone = 1'b1;
		@(negedge clock);
		statusReadDone = 1'b0;
	endtask
endmodule

// ==== testbench/axis_main_status_word_test.sv ====
// Self-checking bench for the per-axis main status word
`timescale 1ns/10ps

module axis_main_status_word_test;
	// Design inputs and outputs
	logic                      clock, rst, startCmdWritten, operationStopped, stopIrqEvent, stopIrqClearCmd;
	logic                      stopIrqEnable, statusClearMode, busyPinN, comparatorAMet, comparatorBMet;
	logic                      offTargetStop, preregisterFull, axisSelectDone, statusReadDone;
	amsw_pkg::amsw_seq_t       seq;
	amsw_pkg::amsw_limit_sel_t sel;
	amsw_pkg::amsw_cause_t     errorCauseReg, eventCauseReg;
	amsw_pkg::amsw_count_t     cnt[4];
	amsw_pkg::amsw_count_t     cmp3, cmp4;
	amsw_pkg::amsw_word_t      mainStatusWord, lastWord;
	// Reference model state and bookkeeping
	int                        mStart = 0, mStopped = 0, mStopF = 0, mErr = 0, mEvt = 0;
	int                        nErrors = 0, checks = 0;
	logic [31:0]               seed = 32'h0000_A3C2;

	// Block under test
	amsw_status_word i_dut
	(
		.clock(clock), .rst(rst), .startCmdWritten(startCmdWritten), .operationStopped(operationStopped),
		.stopIrqEvent(stopIrqEvent), .stopIrqClearCmd(stopIrqClearCmd), .stopIrqEnable(stopIrqEnable),
		.statusClearMode(statusClearMode), .sequenceNumberSetting(seq), .softLimitCounterSelect(sel),
		.busyPinN(busyPinN), .comparatorAMet(comparatorAMet), .comparatorBMet(comparatorBMet),
		.offTargetStop(offTargetStop), .preregisterFull(preregisterFull), .errorCauseReg(errorCauseReg),
		.eventCauseReg(eventCauseReg), .counterCommand(cnt[0]), .counterMechanical(cnt[1]),
		.counterDeviation(cnt[2]), .counterGeneral(cnt[3]), .compareValueThree(cmp3),
		.compareValueFour(cmp4), .axisSelectDone(axisSelectDone), .statusReadDone(statusReadDone),
		.mainStatusWord(mainStatusWord)
	);

	// Host reading the word
	amsw_host_model i_host
	(
		.clock(clock), .axisSelectDone(axisSelectDone), .statusReadDone(statusReadDone),
		.mainStatusWord(mainStatusWord)
	);

	// Reference clock, 25 ns period
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Xorshift source of stimulus
	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Word the model expects from its state and the present levels
	function automatic amsw_pkg::amsw_word_t expWord();
		int c;
		c = cnt[sel];
		return {1'b0, preregisterFull, offTargetStop, 1'b0, c < int'(cmp4), c > int'(cmp3), comparatorBMet,
			comparatorAMet, seq, mEvt[0], mErr[0], mStopped[0], stopIrqEnable & mStopF[0], ~busyPinN, mStart[0]};
	endfunction

	// Compare and count
	task automatic chk(input amsw_pkg::amsw_word_t seen, input amsw_pkg::amsw_word_t exp);
		checks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("BAD %0t word %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic finishTest();
		if (nErrors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One-cycle sequencer pulses and their effect on the model
	task automatic pulse(input logic s, input logic p, input logic e, input logic c);
		@(negedge clock);
		{startCmdWritten, operationStopped, stopIrqEvent, stopIrqClearCmd} = {s, p, e, c};
		@(negedge clock);
		{startCmdWritten, operationStopped, stopIrqEvent, stopIrqClearCmd} = 4'h0;
		mStopF = stopIrqEnable && (e || (mStopF != 0 && !(c && statusClearMode)));
		mStart = s || (mStart != 0 && !p);
		mStopped = p || (mStopped != 0 && !s);
	endtask

	// Cause registers: pending set on a rising bit, dropped when all bits are gone
	task automatic setCause(input amsw_pkg::amsw_cause_t er, input amsw_pkg::amsw_cause_t ev);
		@(negedge clock);
		mErr = ((er & ~errorCauseReg) != 0) || (er != 0 && mErr != 0);
		mEvt = ((ev & ~eventCauseReg) != 0) || (ev != 0 && mEvt != 0);
		errorCauseReg = er;
		eventCauseReg = ev;
	endtask

	// Random levels, settings, counters and compare values, equality hit now and then
	task automatic randLevels();
		logic [31:0] r;
		@(negedge clock);
		r = nextRand();
		{busyPinN, comparatorAMet, comparatorBMet, offTargetStop, preregisterFull} = r[4:0];
		seq = r[7:6];
		sel = amsw_pkg::amsw_limit_sel_t'(r[9:8]);
		stopIrqEnable = r[12] | r[13];
		statusClearMode = r[14];
		for (int i = 0; i < 4; i++)
			cnt[i] = nextRand();
		cmp3 = r[10] ? cnt[sel] : nextRand();
		cmp4 = r[11] ? cnt[sel] : nextRand();
		if (!stopIrqEnable)
			mStopF = 0;
	endtask

	// Settle, read through the host and apply clear-on-read to the model
	task automatic rd(input int gap);
		amsw_pkg::amsw_word_t exp;
		repeat (2) @(negedge clock);
		exp = expWord();
		i_host.read_word(lastWord, gap);
		chk(lastWord, exp);
		if (!statusClearMode && exp[2])
			mStopF = 0;
	endtask

	// Main sequence
	initial
	begin
		logic [31:0] r;
		rst = 1'b1;
		{startCmdWritten, operationStopped, stopIrqEvent, stopIrqClearCmd, stopIrqEnable} = 5'h00;
		{statusClearMode, busyPinN, comparatorAMet, comparatorBMet, offTargetStop, preregisterFull} = 6'h00;
		seq = 2'h0;
		sel = amsw_pkg::AMSW_SEL_COMMAND;
		{errorCauseReg, eventCauseReg, cmp3, cmp4} = 128'h0;
		cnt = '{default: 32'h0000_0000};
		repeat (12) @(negedge clock);
		chk(mainStatusWord, 16'h0000);
		rst = 1'b0;
		// Random traffic of pulses, levels and causes
		for (int i = 0; i < 24; i++)
		begin
			r = nextRand();
			randLevels();
			pulse(r[0], r[1], r[2], r[3]);
			setCause(nextRand() & 32'h0000_0003, nextRand() & 32'h0000_0006);
			rd(int'(r[5:4]));
		end
		// Snapshot holds while a live level moves
		busyPinN = ~busyPinN;
		seq = ~seq;
		repeat (3) @(negedge clock);
		chk(mainStatusWord, lastWord);
		// Stop flag clears on read in mode zero and only by command in mode one
		stopIrqEnable = 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			statusClearMode = m[0];
			pulse(1'b0, 1'b0, 1'b1, 1'b0);
			rd(1);
			rd(2);
			pulse(1'b0, 1'b0, 1'b0, 1'b1);
			rd(0);
		end
		// Disabled stop interrupt reads zero
		stopIrqEnable = 1'b0;
		mStopF = 0;
		pulse(1'b0, 1'b0, 1'b1, 1'b0);
		rd(0);
		// Pending bits stay while any cause bit remains
		setCause(32'h0000_0005, 32'h8000_0000);
		rd(0);
		setCause(32'h0000_0004, 32'h0000_0000);
		rd(0);
		setCause(32'h0000_0000, 32'h0000_0000);
		rd(0);
		// Limits at their boundaries on every selectable counter
		sel = amsw_pkg::AMSW_SEL_DEVIATION;
		cnt[2] = 32'h7FFF_FFFF;
		cmp3 = 32'h7FFF_FFFF;
		rd(0);
		cmp3 = 32'h7FFF_FFFE;
		cmp4 = 32'h7FFF_FFFF;
		rd(0);
		cnt[2] = 32'h7FFF_FFFE;
		rd(0);
		for (int k = 0; k < 4; k++)
		begin
			sel = amsw_pkg::amsw_limit_sel_t'(k);
			cnt[k] = cmp3 + 1;
			rd(0);
		end
		finishTest();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		nErrors++;
		finishTest();
	end
endmodule
